// [rtl/fct_params.svh]
// Constants for the feedback conversion table: field positions, methods,
// address layout of the interface channels and arithmetic shifts.
// Assumes 24-bit setup and result words and a 16-bit source address space.
`ifndef FCT_PARAMS_SVH
`define FCT_PARAMS_SVH

`define FCT_LINES 6'h20
`define FCT_W 24
`define FCT_METHOD_HI 23
`define FCT_METHOD_LO 20
`define FCT_DIGIT_HI 19
`define FCT_DIGIT_LO 16
`define FCT_SRC_HI 15
`define FCT_SRC_LO 0
`define FCT_FRAC 5
`define FCT_ENC_BASE 16'hC000
`define FCT_CHANNELS 16'h0010
`define FCT_STRIDE_OLD 16'h0004
`define FCT_STRIDE_NEW 16'h0008
`define FCT_FLAG_OFS_OLD 16'h0004
`define FCT_FLAG_LSB 19
`define FCT_T_SINCE_OFS 16'h0001
`define FCT_T_BETWEEN_OFS 16'h0002
`define FCT_ADC_SHIFT 3
`define FCT_BIAS_SHIFT 3
`define FCT_TB_SHIFT 16
`define FCT_FILT_SHIFT 23
`define FCT_FRAC_MAX 5'h1F
`define FCT_DIV_STEPS 3'h5

`define FCT_M_ENC_1T 4'h0
`define FCT_M_ADC 4'h1
`define FCT_M_PAR_Y 4'h2
`define FCT_M_PAR_YF 4'h3
`define FCT_M_TB 4'h4
`define FCT_M_ADC_INT 4'h5
`define FCT_M_PAR_X 4'h6
`define FCT_M_PAR_XF 4'h7
`define FCT_M_ENC_PAR 4'h8
`define FCT_M_TB_FROZEN 4'h9
`define FCT_M_TB_RUN 4'hA
`define FCT_M_TB_ARMED 4'hB
`define FCT_M_ENC_NONE 4'hC
`define FCT_M_EXP_FILT 4'hD
`define FCT_M_RESERVED 4'hE
`define FCT_M_INTERP 4'hF

`endif

// [rtl/fct_pkg.sv]
// Types shared by the feedback conversion table and its bench.
// Assumes fct_params.svh is on the include path.
`default_nettype none
`include "fct_params.svh"

package fct_pkg;

   typedef enum logic [2:0] {
      FCT_IDLE = 3'h0,
      FCT_LINE = 3'h1,
      FCT_REQ = 3'h2,
      FCT_DIV = 3'h3,
      FCT_CALC = 3'h4,
      FCT_DONE = 3'h5
   } fct_state_e;

   typedef logic [`FCT_W-1:0] fct_word_t;

   // Read request toward the interface channel registers
   typedef struct packed {
      logic valid;
      logic x_space;
      logic [15:0] addr;
   } fct_src_req_s;

   // Setup write port
   typedef struct packed {
      logic en;
      logic [4:0] index;
      fct_word_t data;
   } fct_setup_wr_s;

   typedef struct packed {
      fct_state_e stt;
      logic [31:0][`FCT_W-1:0] setup;
      logic [31:0][`FCT_W-1:0] result;
      logic [31:0][`FCT_W-1:0] hist;
      logic [5:0] ptr;
      logic [1:0] rd_cnt;
      logic [2:0][`FCT_W-1:0] word;
      logic [`FCT_W:0] rem;
      logic [4:0] quo;
      logic [2:0] div_cnt;
      fct_word_t prev_final;
      logic bad;
      logic done;
      fct_word_t rd_data;
   } fct_state_s;

endpackage

`default_nettype wire

// [rtl/fct_table.sv]
// Feedback conversion table: walks up to 32 setup lines once per servo
// tick, reads raw feedback words and writes processed results.
// Assumes the channel register side answers each read with src_ack.
//
// Operation
// R1: Each entry spans one, two or three lines depending on method.
// R2: Method code is the top hex digit, bits 20 to 23.
// R3: Encoder results are in 1/32 count, low 5 bits fractional.
// R4: 1/T fraction is time since last count over time between counts.
// R5: Parallel extension takes five flags from bit 19, base or base+4.
// R6: No-extension encoder method forces the fraction bits to zero.
// R7: Encoder source address field points at the channel's first register.
// R8: Older style channel bases start at C000, stride 4, channels 1-16.
// R9: Newer style channel bases start at C000, stride 8, channels 1-16.
// R10: Encoder digit 0 is stand-alone, 1 adds the preceding entry result.
// R11: A/D methods take high 16 source bits, LSB landing at bit 5.
// R12: A/D methods do no rollover extension; parallel methods track wrap.
// R13: Unfiltered parallel methods use two lines, second a bit mask.
// R14: Filtered parallel methods use three lines: mask then max change.
// R15: Parallel digit: 0 shift, 1 shift summed, 8 none, 9 none summed.
// R16: Time-base methods use two lines holding the scale factor.
// R17: Exponential filter uses three lines: max change then gain.
// R18: Interpolator uses two lines, A/D address; digit 0 old, 8 new.
// R19: Method E is reserved and converts nothing.
// R20: An all-zero first line ends the table for this cycle.
// R21: Each line has a result; the entry's last line holds the final.
// R22: Integrated A/D shifts input, applies bias, accumulates the result.
// R23: Summing adds the preceding entry's final result before storing.
// R24: All active entries run once per servo tick in ascending order.
`default_nettype none
`include "fct_params.svh"

module fct_table
   import fct_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic servo_tick,
   input wire logic style_new,
   input wire fct_setup_wr_s setup_wr,
   input wire logic [4:0] result_rd_index,
   output fct_word_t result_rd_data,
   output fct_src_req_s src_req,
   input wire logic src_ack,
   input wire fct_word_t src_data,
   output logic busy,
   output logic cycle_done,
   output logic bad_source
);

   fct_state_s st;
   fct_state_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Lines past the end of the table read as zero
   function automatic fct_word_t line_at(input logic [5:0] i);
      line_at = (i < `FCT_LINES) ? st.setup[i[4:0]] : '0;
   endfunction

   // Lines per entry from the method code
   function automatic logic [5:0] entry_len(input logic [3:0] m);
      case (m)
         `FCT_M_PAR_Y, `FCT_M_PAR_X, `FCT_M_TB, `FCT_M_ADC_INT, `FCT_M_TB_FROZEN,
         `FCT_M_TB_RUN, `FCT_M_TB_ARMED, `FCT_M_INTERP:
            entry_len = 6'h02; // R1 R13 R16 R18
         `FCT_M_PAR_YF, `FCT_M_PAR_XF, `FCT_M_EXP_FILT:
            entry_len = 6'h03; // R1 R14 R17
         default:
            entry_len = 6'h01; // R1
      endcase
   endfunction

   // Source words fetched per entry
   function automatic logic [1:0] read_count(input logic [3:0] m);
      case (m)
         `FCT_M_ENC_1T: read_count = 2'h3;
         `FCT_M_ENC_PAR, `FCT_M_INTERP: read_count = 2'h2;
         default: read_count = 2'h1;
      endcase
   endfunction

   // Clamp a signed change to plus or minus a limit
   function automatic fct_word_t clamp(input fct_word_t v, input fct_word_t lim);
      if ($signed(v) > $signed(lim))
         clamp = lim;
      else if ($signed(v) < -$signed(lim))
         clamp = -lim;
      else
         clamp = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and arithmetic

   always_comb
   begin
      fct_word_t first;
      fct_word_t l1;
      fct_word_t l2;
      logic [3:0] method;
      logic [3:0] digit;
      logic [15:0] src;
      logic [15:0] ofs;
      logic [15:0] stride;
      logic [5:0] len;
      logic [5:0] last;
      logic [4:0] frac;
      fct_word_t w0;
      fct_word_t masked;
      fct_word_t delta;
      fct_word_t shifted;
      fct_word_t acc;
      fct_word_t final_val;
      fct_word_t sum_in;
      logic [`FCT_W:0] trial;
      logic signed [47:0] prod;

      next_st = st;
      next_st.done = 1'b0;
      src_req = '0;
      first = line_at(st.ptr);
      l1 = line_at(st.ptr + 6'h01);
      l2 = line_at(st.ptr + 6'h02);
      method = first[`FCT_METHOD_HI:`FCT_METHOD_LO]; // R2
      digit = first[`FCT_DIGIT_HI:`FCT_DIGIT_LO];
      src = first[`FCT_SRC_HI:`FCT_SRC_LO];
      len = entry_len(method);
      last = st.ptr + len - 6'h01;
      stride = style_new ? `FCT_STRIDE_NEW : `FCT_STRIDE_OLD;
      ofs = src - `FCT_ENC_BASE;
      frac = '0;
      w0 = st.word[0];
      masked = '0;
      delta = '0;
      shifted = '0;
      acc = '0;
      final_val = '0;
      sum_in = digit[0] ? st.prev_final : '0; // R10 R15 R23
      trial = '0;
      prod = '0;

      case (st.stt)
         FCT_IDLE:
         begin
            // Ticks during a pass are dropped; the pass must fit the servo period
            if (servo_tick)
            begin
               next_st.stt = FCT_LINE; // R24
               next_st.ptr = '0;
               next_st.prev_final = '0;
               next_st.bad = 1'b0;
            end
         end
         FCT_LINE:
         begin
            if (st.ptr >= `FCT_LINES || first == '0)
               next_st.stt = FCT_DONE; // R20
            else if (method == `FCT_M_RESERVED)
               next_st.ptr = st.ptr + 6'h01; // R19
            else
            begin
               next_st.rd_cnt = '0;
               next_st.stt = FCT_REQ;
               // Encoder sources must hit a channel base for the chosen style
               if (method == `FCT_M_ENC_1T || method == `FCT_M_ENC_PAR ||
                   method == `FCT_M_ENC_NONE)
                  if (src < `FCT_ENC_BASE || ofs >= `FCT_CHANNELS * stride ||
                      (ofs & (stride - 16'h0001)) != '0)
                     next_st.bad = 1'b1; // R7 R8 R9
            end
         end
         FCT_REQ:
         begin
            src_req.valid = 1'b1;
            src_req.x_space = (method == `FCT_M_PAR_X || method == `FCT_M_PAR_XF);
            src_req.addr = src;
            if (method == `FCT_M_ENC_1T)
               src_req.addr = src + ((st.rd_cnt == 2'h1) ? `FCT_T_SINCE_OFS :
                  (st.rd_cnt == 2'h2) ? `FCT_T_BETWEEN_OFS : 16'h0000); // R4 R7
            else if (method == `FCT_M_ENC_PAR && st.rd_cnt == 2'h1)
               src_req.addr = style_new ? src : src + `FCT_FLAG_OFS_OLD; // R5
            else if (method == `FCT_M_INTERP && st.rd_cnt == 2'h1)
               src_req.addr = l1[`FCT_SRC_HI:`FCT_SRC_LO]; // R18
            if (src_ack)
            begin
               next_st.word[st.rd_cnt] = src_data;
               next_st.rd_cnt = st.rd_cnt + 2'h1;
               if (st.rd_cnt == read_count(method) - 2'h1)
               begin
                  next_st.stt = (method == `FCT_M_ENC_1T) ? FCT_DIV : FCT_CALC;
                  next_st.rem = {1'b0, (st.rd_cnt == 2'h0) ? src_data : st.word[1]};
                  next_st.quo = '0;
                  next_st.div_cnt = '0;
               end
            end
         end
         FCT_DIV:
         begin
            // One quotient bit per cycle keeps the divider to one subtractor
            trial = {st.rem[`FCT_W-1:0], 1'b0};
            next_st.rem = trial;
            next_st.quo = {st.quo[3:0], 1'b0};
            if (trial >= {1'b0, st.word[2]})
            begin
               next_st.rem = trial - {1'b0, st.word[2]};
               next_st.quo = {st.quo[3:0], 1'b1};
            end
            next_st.div_cnt = st.div_cnt + 3'h1;
            if (st.div_cnt == `FCT_DIV_STEPS - 3'h1)
               next_st.stt = FCT_CALC;
         end
         FCT_CALC:
         begin
            case (method)
               `FCT_M_ENC_1T, `FCT_M_ENC_PAR, `FCT_M_ENC_NONE, `FCT_M_INTERP:
               begin
                  if (method == `FCT_M_ENC_1T)
                     // Stopped encoder zeroes the fraction; since >= between saturates it
                     frac = (st.word[2] == '0) ? 5'h00 :
                        (st.word[1] >= st.word[2]) ? `FCT_FRAC_MAX : st.quo; // R4
                  else if (method == `FCT_M_ENC_PAR)
                     frac = st.word[1][`FCT_FLAG_LSB +: `FCT_FRAC]; // R5
                  else if (method == `FCT_M_INTERP)
                     frac = digit[3] ? st.word[1][`FCT_FLAG_LSB +: `FCT_FRAC] :
                        st.word[1][`FCT_SRC_HI -: `FCT_FRAC]; // R18
                  else
                     frac = '0; // R6
                  acc = {w0[`FCT_W-`FCT_FRAC-1:0], frac}; // R3
                  if (method == `FCT_M_INTERP)
                     next_st.result[st.ptr[4:0]] = w0;
                  final_val = acc + ((method == `FCT_M_INTERP) ? '0 : sum_in); // R10
               end
               `FCT_M_ADC, `FCT_M_ADC_INT:
               begin
                  // High 16 bits only, no wrap tracking across cycles
                  shifted = digit[3] ? (w0 >> `FCT_ADC_SHIFT) :
                     fct_word_t'($signed(w0) >>> `FCT_ADC_SHIFT); // R11 R12
                  shifted[`FCT_FRAC-1:0] = '0; // R11
                  if (method == `FCT_M_ADC)
                     final_val = shifted + sum_in; // R23
                  else
                  begin
                     delta = shifted - fct_word_t'($signed(l1) >>> `FCT_BIAS_SHIFT); // R22
                     if (digit[3] && $signed(delta) < 0)
                        delta = '0;
                     next_st.result[st.ptr[4:0]] = delta; // R21
                     final_val = st.result[last[4:0]] + delta; // R22
                  end
               end
               `FCT_M_PAR_Y, `FCT_M_PAR_YF, `FCT_M_PAR_X, `FCT_M_PAR_XF:
               begin
                  masked = w0 & l1; // R13
                  delta = masked - st.hist[st.ptr[4:0]];
                  // A rise past half the mask counts as a small step down; a fall in the masked word also loses mask plus one
                  if (delta > (l1 >> 1))
                     delta = delta - l1 - 24'h000001; // R12
                  if (len == 6'h03)
                  begin
                     delta = clamp(delta, l2); // R14
                     next_st.result[st.ptr[4:0] + 5'h01] = delta; // R21
                  end
                  if (digit[3:2] == 2'b11)
                     shifted = fct_word_t'($signed(delta) >>> `FCT_ADC_SHIFT);
                  else if (digit[3])
                     shifted = delta; // R15
                  else
                     shifted = delta << `FCT_FRAC; // R15
                  next_st.hist[st.ptr[4:0]] = masked;
                  acc = st.result[st.ptr[4:0]] + shifted;
                  next_st.result[st.ptr[4:0]] = acc; // R21
                  final_val = acc + sum_in; // R15 R23
               end
               `FCT_M_TB, `FCT_M_TB_FROZEN, `FCT_M_TB_RUN, `FCT_M_TB_ARMED:
               begin
                  delta = w0 - st.hist[st.ptr[4:0]];
                  prod = $signed(delta) * $signed(l1); // R16
                  next_st.hist[st.ptr[4:0]] = w0;
                  next_st.result[st.ptr[4:0]] = delta; // R21
                  // Frozen and armed always hold the time base at zero
                  final_val = (method == `FCT_M_TB || method == `FCT_M_TB_RUN) ?
                     prod[`FCT_TB_SHIFT +: `FCT_W] : '0; // R16
               end
               `FCT_M_EXP_FILT:
               begin
                  delta = clamp(w0 - st.result[last[4:0]], l1); // R17
                  prod = $signed(delta) * $signed(l2); // R17
                  next_st.result[st.ptr[4:0]] = delta; // R21
                  next_st.result[st.ptr[4:0] + 5'h01] = prod[`FCT_FILT_SHIFT +: `FCT_W];
                  final_val = st.result[last[4:0]] + prod[`FCT_FILT_SHIFT +: `FCT_W];
               end
               default:
                  final_val = st.result[last[4:0]];
            endcase
            next_st.result[last[4:0]] = final_val; // R21
            next_st.prev_final = final_val; // R23
            next_st.ptr = st.ptr + len; // R1 R24
            next_st.stt = FCT_LINE;
         end
         FCT_DONE:
         begin
            next_st.done = 1'b1;
            next_st.stt = FCT_IDLE;
         end
         default:
            next_st.stt = FCT_IDLE;
      endcase

      // Software setup writes land last so they are never lost
      if (setup_wr.en)
         next_st.setup[setup_wr.index] = setup_wr.data;
      next_st.rd_data = st.result[result_rd_index];
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st <= '0;
         st.stt <= FCT_IDLE;
      end
      else
         st <= next_st;
   end

   // Outputs
   assign result_rd_data = st.rd_data;
   assign busy = (st.stt != FCT_IDLE);
   assign cycle_done = st.done;
   assign bad_source = st.bad;

endmodule

`default_nettype wire

// [sim/fct_chk.sv]
// Checker for the conversion table: tick, pass and source read timing.
// Assumes it sees only the top ports; bound into every fct_table.
`default_nettype none
module fct_chk
   import fct_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic servo_tick,
   input wire fct_src_req_s src_req,
   input wire logic src_ack,
   input wire logic busy,
   input wire logic cycle_done,
   input wire logic bad_source
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Steps of a pass: a tick taken while idle, a read left waiting
   sequence s_accept;
      servo_tick && !busy;
   endsequence
   sequence s_wait;
      src_req.valid && !src_ack;
   endsequence
   AST_REQ_HOLD: assert property (s_wait |=> src_req.valid && $stable(src_req.addr))
      else $error("source read moved before ack");
   AST_TICK_BUSY: assert property (s_accept |=> busy)
      else $error("accepted tick did not start a pass");
   AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(servo_tick))
      else $error("pass started without a tick");
   AST_IDLE_QUIET: assert property (!busy |-> !src_req.valid)
      else $error("source read outside a pass");
   AST_DONE_PULSE: assert property (cycle_done |=> !cycle_done)
      else $error("pass end longer than one cycle");
   AST_DONE_IDLE: assert property (cycle_done |-> !busy && $past(busy))
      else $error("pass end not at busy fall");
   AST_DONE_AT_END: assert property ($fell(busy) |-> cycle_done)
      else $error("busy fell without pass end");
   AST_BAD_CLEAR: assert property (s_accept |=> !bad_source)
      else $error("bad source not cleared by tick");
   AST_BAD_HOLD: assert property (bad_source && !servo_tick |=> bad_source)
      else $error("bad source dropped mid pass");
endmodule

bind fct_table fct_chk fct_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
   .servo_tick(servo_tick), .src_req(src_req), .src_ack(src_ack), .busy(busy),
   .cycle_done(cycle_done), .bad_source(bad_source));
`default_nettype wire

// [sim/fct_src_model.sv]
// Behavioural channel register bank answering the table's source reads.
// Assumes the bench fills mem by hierarchy before each pass.
// X-space words are keyed one bit above the 16-bit address, Y-space words plain.
`default_nettype none
module fct_src_model
   import fct_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire fct_src_req_s src_req,
   input wire logic slow,
   output logic src_ack,
   output fct_word_t src_data
);
   timeunit 1ns;
   timeprecision 1ns;
   fct_word_t mem [int];
   logic [1:0] wait_cnt;
   initial src_data = 24'h5A5A5A;
   ////////////////////////////////////////////////////////////////////////////////
   // Slow mode waits two cycles; idle data churns so a stale sample shows up
   always @(posedge mclk)
   begin
      if (sys_rst || src_ack || !src_req.valid)
      begin
         src_ack <= 1'b0;
         wait_cnt <= 2'h0;
         src_data <= ~src_data;
      end
      else if (!slow || wait_cnt == 2'h2)
      begin
         src_ack <= 1'b1;
         src_data <= mem.exists(int'({src_req.x_space, src_req.addr})) ?
            mem[int'({src_req.x_space, src_req.addr})] : 24'h000000;
      end
      else
      begin
         wait_cnt <= wait_cnt + 2'h1;
         src_data <= ~src_data;
      end
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the conversion table with a channel model.
// Assumes fct_pkg is compiled first; results are read back by index.
`default_nettype none
module testbench
   import fct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {string nm; fct_word_t v;} fct_note_s;
   fct_note_s notes[$];
   fct_note_s nt;
   logic mclk, sys_rst, servo_tick, style_new, slow, src_ack, busy, cycle_done, bad_source;
   logic rd_due;
   logic [4:0] rd_idx;
   fct_word_t rd_data, src_data;
   fct_setup_wr_s setup_wr;
   fct_src_req_s src_req;
   int mismatches = 0;
   int cmp_count = 0;
   int seed = 68220;
   fct_table fct_table_inst (.mclk(mclk), .sys_rst(sys_rst), .servo_tick(servo_tick),
      .style_new(style_new), .setup_wr(setup_wr), .result_rd_index(rd_idx),
      .result_rd_data(rd_data), .src_req(src_req), .src_ack(src_ack),
      .src_data(src_data), .busy(busy), .cycle_done(cycle_done), .bad_source(bad_source));
   fct_src_model src_model_inst (.mclk(mclk), .sys_rst(sys_rst), .src_req(src_req),
      .slow(slow), .src_ack(src_ack), .src_data(src_data));
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, fct_word_t exp, fct_word_t got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset();
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
   endtask
   task automatic wr(input logic [4:0] i, input fct_word_t d);
      @(negedge mclk);
      setup_wr = '{1'b1, i, d};
   endtask
   // Bounded wait so a stuck sequencer cannot hang the run
   task automatic run_pass();
      int n;
      n = 0;
      @(negedge mclk);
      setup_wr.en = 1'b0;
      servo_tick = 1'b1;
      @(negedge mclk);
      servo_tick = 1'b0;
      while (cycle_done !== 1'b1 && n < 400)
      begin
         @(negedge mclk);
         n++;
      end
      check("pass_end", 24'h000001, 24'(n < 400));
   endtask
   task automatic read_res(input logic [4:0] i, input fct_word_t e, input string nm);
      @(negedge mclk);
      rd_idx = i;
      notes.push_back('{nm, e});
      rd_due = 1'b1;
      @(negedge mclk);
      rd_due = 1'b0;
   endtask
   function automatic fct_word_t enc(input fct_word_t d);
      return {d[18:0], 5'h00};
   endfunction
   // Result watcher: one note per read, taken once the read data settles
   always @(posedge mclk)
      if (rd_due === 1'b1)
      begin
         #1;
         nt = notes.pop_front();
         check(nt.nm, nt.v, rd_data);
      end
   initial
   begin
      #400000;
      mismatches++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fct_word_t d, e, f, b, s;
      logic [15:0] a;
      logic [3:0] dg;
      sys_rst = 1'b1;
      servo_tick = 1'b0;
      style_new = 1'b0;
      slow = 1'b0;
      rd_due = 1'b0;
      rd_idx = 5'h00;
      setup_wr = '0;
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      read_res(5'h00, 24'h000000, "reset_result");
      // Channel bases in both styles, one misplaced base per style
      for (int st = 0; st < 2; st++)
         for (int k = 0; k < 17; k++)
         begin
            style_new = st[0];
            a = (k == 16) ? (st ? 16'hC004 : 16'hC002) : 16'hC000 + 16'(k * (st ? 8 : 4));
            d = $random(seed);
            src_model_inst.mem[int'(a)] = d;
            wr(5'h00, {8'hC0, a});
            wr(5'h01, 24'h000000);
            slow = k[0];
            run_pass();
            check("bad_source", 24'(k == 16), 24'(bad_source));
            read_res(5'h00, enc(d), "no_extension");
         end
      $display("test base_sweep done");
      // Summing, reserved code and table end
      do_reset();
      style_new = 1'b0;
      d = $random(seed);
      e = $random(seed);
      f = $random(seed);
      src_model_inst.mem[32'hC000] = d;
      src_model_inst.mem[32'hC004] = e;
      src_model_inst.mem[32'hC008] = f;
      wr(5'h00, 24'hC0C000);
      wr(5'h01, 24'hC1C004);
      wr(5'h02, 24'hE00000);
      wr(5'h03, 24'hC0C008);
      wr(5'h04, 24'h000000);
      wr(5'h05, 24'hC0C000);
      run_pass();
      read_res(5'h00, enc(d), "first_entry");
      read_res(5'h01, enc(d) + enc(e), "summed");
      read_res(5'h02, 24'h000000, "reserved");
      read_res(5'h03, enc(f), "after_reserved");
      read_res(5'h05, 24'h000000, "past_end");
      $display("test sum_end done");
      // Time ratio fraction, last case saturating
      wr(5'h00, 24'h00C000);
      wr(5'h01, 24'h000000);
      for (int i = 0; i < 4; i++)
      begin
         d = $random(seed);
         b = ($random(seed) & 24'h000FFF) | 24'h000001;
         s = (i == 3) ? b + 24'h000001 : (($random(seed) & 24'h000FFF) % b);
         src_model_inst.mem[32'hC000] = d;
         src_model_inst.mem[32'hC001] = s;
         src_model_inst.mem[32'hC002] = b;
         slow = i[0];
         run_pass();
         e = (i == 3) ? 24'h00001F : (s * 32) / b;
         read_res(5'h00, {d[18:0], e[4:0]}, "time_ratio");
      end
      // Flag fraction at base or base plus 4
      wr(5'h00, 24'h80C000);
      for (int st = 0; st < 2; st++)
      begin
         style_new = st[0];
         d = $random(seed);
         f = $random(seed);
         src_model_inst.mem[32'hC000] = d;
         src_model_inst.mem[32'hC004] = f;
         run_pass();
         e = st ? d : f;
         read_res(5'h00, {d[18:0], e[23:19]}, "flag_fraction");
      end
      $display("test extension done");
      // A/D words, signed and unsigned, four passes with no carry over
      for (int i = 0; i < 4; i++)
      begin
         dg = i[1] ? 4'h8 : 4'h0;
         d = $random(seed) | 24'h800000;
         src_model_inst.mem[32'hC006] = d;
         wr(5'h00, {4'h1, dg, 16'hC006});
         run_pass();
         e = {dg[3] ? 3'h0 : {3{d[23]}}, d[23:8], 5'h00};
         read_res(5'h00, e, "adc");
      end
      $display("test adc done");
      // Parallel word, shift and sum digits 0, 1, 8 and 9
      for (int i = 0; i < 4; i++)
      begin
         dg = {i[1], 2'h0, i[0]};
         do_reset();
         d = $random(seed);
         src_model_inst.mem[32'hC000] = d;
         src_model_inst.mem[32'hC010] = 24'hABC123;
         wr(5'h00, 24'hC0C000);
         wr(5'h01, {4'h2, dg, 16'hC010});
         wr(5'h02, 24'h000FFF);
         wr(5'h03, 24'h000000);
         run_pass();
         e = (dg[3] ? 24'h000123 : 24'h002460) + (dg[0] ? enc(d) : 24'h000000);
         read_res(5'h02, e, "parallel");
      end
      $display("test parallel done");
      // Filtered X word, time base, integrated A/D, interpolator, exponential filter
      do_reset();
      src_model_inst.mem[32'h1C020] = 24'h000100;
      src_model_inst.mem[32'hC030] = 24'h000123;
      src_model_inst.mem[32'hC040] = 24'h012300;
      src_model_inst.mem[32'hC050] = 24'h000040;
      src_model_inst.mem[32'hC060] = 24'hF80000;
      src_model_inst.mem[32'hC070] = 24'h000080;
      wr(5'h00, 24'h70C020);
      wr(5'h01, 24'h000FFF);
      wr(5'h02, 24'h000010);
      wr(5'h03, 24'h40C030);
      wr(5'h04, 24'h020000);
      wr(5'h05, 24'h50C040);
      wr(5'h06, 24'h000800);
      wr(5'h07, 24'hF8C050);
      wr(5'h08, 24'h00C060);
      wr(5'h09, 24'hD0C070);
      wr(5'h0A, 24'h000100);
      wr(5'h0B, 24'h400000);
      run_pass();
      read_res(5'h02, 24'h000200, "filtered_x");
      read_res(5'h04, 24'h000246, "time_base");
      read_res(5'h06, 24'h002360, "adc_integrated");
      read_res(5'h08, 24'h00081F, "interpolator");
      read_res(5'h0B, 24'h000040, "exp_filter");
      // Second pass: integration and filter build on the stored results
      run_pass();
      read_res(5'h06, 24'h0046C0, "adc_accumulated");
      read_res(5'h0B, 24'h000060, "exp_filter_step");
      $display("test methods done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
